// File: common/bsl_pkg.sv
// shared constants and types for the bridge error and lock control pair
// assumes a single 10 MHz clock shared by both ends
package bsl_pkg;
    // ****************************************************************
    // register map (byte offsets on the avalon slave)
    // ****************************************************************
    localparam logic [4:0] BSL_OFF_CMD = 5'h00;
    localparam logic [4:0] BSL_OFF_STAT = 5'h04;
    localparam logic [4:0] BSL_OFF_BRC = 5'h08;
    localparam logic [4:0] BSL_OFF_DIS = 5'h0C;
    localparam logic [4:0] BSL_OFF_RSN = 5'h10;
    localparam logic [4:0] BSL_OFF_MTO = 5'h14;
    // command register fields
    localparam int BSL_CMD_PERR = 0;
    localparam int BSL_CMD_SERR = 1;
    // bridge control fields
    localparam int BSL_BRC_PERR = 0;
    localparam int BSL_BRC_FWD = 1;
    localparam int BSL_BRC_MAM = 2;
    localparam int BSL_BRC_MTO = 3;
    // status fields
    localparam int BSL_ST_SSE = 0;
    localparam int BSL_ST_RSE = 1;
    localparam int BSL_ST_DPE = 2;
    localparam int BSL_ST_PLK = 3;
    localparam int BSL_ST_SLK = 4;
    localparam int BSL_ST_PEND = 5;
    // error event / reason bit positions
    localparam int BSL_EV_PW_PAR = 0;
    localparam int BSL_EV_PW_TABT = 1;
    localparam int BSL_EV_PW_MABT = 2;
    localparam int BSL_EV_PW_RTY = 3;
    localparam int BSL_EV_DW_RTY = 4;
    localparam int BSL_EV_DR_RTY = 5;
    localparam int BSL_EV_MTO = 6;
    localparam int BSL_EV_SFWD = 7;
    // reset values
    localparam logic [1:0] BSL_CMD_RST = 2'h0;
    localparam logic [3:0] BSL_BRC_RST = 4'h0;
    localparam logic [5:0] BSL_DIS_RST = 6'h00;
    localparam logic [15:0] BSL_MTO_RST = 16'h8000;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        BSL_RESP_NONE, BSL_RESP_RETRY, BSL_RESP_FWD, BSL_RESP_DATA,
        BSL_RESP_ABORT
    } bsl_resp_t;
    typedef enum logic [1:0] {BSL_SEC_OK, BSL_SEC_TABT, BSL_SEC_MABT}
        bsl_sec_t;
    typedef enum logic [1:0] {BSL_Q_PW, BSL_Q_DW, BSL_Q_DR} bsl_qkind_t;
endpackage : bsl_pkg

// File: common/bsl_link_if.sv
// primary-bus link between the locking initiator and the bridge control
// assumes both ends run on the same clock; no clocking block
`timescale 1ns/1ps
interface bsl_link_if;
    import bsl_pkg::*;
    logic req_valid;
    logic req_read;
    logic req_mem;
    logic [31:0] req_addr;
    logic [3:0] req_cmd;
    logic [3:0] req_be;
    logic req_par;
    logic frame_n;
    logic lock_n;
    bsl_resp_t resp;
    logic [31:0] rdata;

    modport dev (input req_valid, req_read, req_mem, req_addr, req_cmd,
        req_be, req_par, frame_n, lock_n, output resp, rdata);
    modport ini (output req_valid, req_read, req_mem, req_addr, req_cmd,
        req_be, req_par, frame_n, lock_n, input resp, rdata);
endinterface : bsl_link_if

// File: core/bsl_bridge_ctl.sv
// bridge side: system-error reporting and downstream lock control
// assumes the link initiator is on the same clock, pins are synchronised
// here, and software uses the avalon slave with one wait state
// Operation
// - posted-write parity serr needs both enables
// - no serr unless serr enable set
// - every serr sets signaled flag
// - forward secondary serr, set received flag
// - posted-write aborts raise serr conditionally
// - discard after retry limit, raise serr
// - master timeout serr gated by own enable
// - reason register, per-event disable mask (dis_ff covers six events; timeout and forward have no bit)
// - primary and secondary locks independent
// - initiator checks idle bus, lock free
// - lock deasserted at address, asserted after
// - locks cross downstream only
// - upstream traffic always forwarded unlocked
// - capture locked read, answer retry
// - first locked is read; no prefetch
// - retry all cross traffic while lock pending
// - secondary lock sequence, wait for free lock
// - matching locked repeat returns data, locks primary
// - master timeout discards, releases secondary lock
// - later locked transactions stay locked downstream
// - locked read abort: report, no lock
// - secondary data-parity flag conditions
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
module bsl_bridge_ctl import bsl_pkg::*; #(
    parameter int RETRY_LIMIT = 2**24,
    parameter int NQ = 4
) (
    input wire logic clk,
    input wire logic nrst,
    bsl_link_if.dev link,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic s_serr_n,
    input wire logic s_lock_in_n,
    output logic s_lock_o_n,
    output logic s_lock_oe,
    input wire logic sec_idle,
    input wire logic prior_busy,
    output logic sec_start,
    output logic [31:0] sec_addr,
    output logic [3:0] sec_cmd,
    output logic [3:0] sec_be,
    output logic sec_par,
    input wire logic sec_done,
    input wire bsl_sec_t sec_status,
    input wire logic [31:0] sec_rdata,
    input wire logic pw_perr_rep,
    input wire logic pw_perr_as_tgt,
    input wire logic pw_tabort,
    input wire logic pw_mabort,
    input wire logic q_retry,
    input wire logic [$clog2(NQ)-1:0] q_retry_slot,
    input wire bsl_qkind_t q_retry_kind,
    input wire logic q_done,
    input wire logic [$clog2(NQ)-1:0] q_done_slot,
    output logic q_discard,
    output logic [$clog2(NQ)-1:0] q_discard_slot,
    input wire logic dpe_event,
    input wire logic dpe_down,
    input wire logic dpe_sec_bus,
    input wire logic dpe_master,
    output logic fwd_valid,
    output logic fwd_locked,
    output logic fwd_no_prefetch,
    output logic [31:0] fwd_addr,
    output logic [3:0] fwd_cmd,
    output logic [3:0] fwd_be,
    input wire logic up_req,
    output logic up_fwd,
    output logic p_serr_n,
    output logic pri_lock_held,
    output logic sec_lock_held
);
    localparam int RW = $clog2(RETRY_LIMIT) + 1;
    localparam logic [RW-1:0] RTY_LAST = RW'(RETRY_LIMIT - 1);
    typedef enum logic [2:0] {
        LK_IDLE, LK_QUEUED, LK_SECW, LK_SECA, LK_SECR, LK_WAITI, LK_HELD,
        LK_ABORT
    } bsl_lk_t;

    function automatic logic [7:0] f_w1c(input logic [7:0] q,
        input logic [7:0] s, input logic [7:0] c);
        return s | (q & ~c); // set wins over a same-cycle clear
    endfunction : f_w1c

    // ****************************************************************
    // avalon slave
    // ****************************************************************
    logic ack_ff, wr_fire;
    logic [1:0] cmd_ff;
    logic [3:0] brc_ff;
    logic [5:0] dis_ff;
    logic [15:0] mto_lim_ff;
    logic [2:0] st_ff;
    logic [7:0] rsn_ff;
    bsl_lk_t lk_ff, nxt_lk;

    // one wait state; write and read data land on the edge of acceptance
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign wr_fire = avs_write & ack_ff;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_ff <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
            case (avs_address)
                BSL_OFF_CMD: avs_readdata <= {30'h0000_0000, cmd_ff};
                BSL_OFF_STAT: avs_readdata <= {26'h000_0000,
                    lk_ff != LK_IDLE, sec_lock_held, pri_lock_held, st_ff};
                BSL_OFF_BRC: avs_readdata <= {28'h000_0000, brc_ff};
                BSL_OFF_DIS: avs_readdata <= {26'h000_0000, dis_ff};
                BSL_OFF_RSN: avs_readdata <= {24'h00_0000, rsn_ff};
                BSL_OFF_MTO: avs_readdata <= {16'h0000, mto_lim_ff};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // control registers written by software
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmd_ff <= BSL_CMD_RST;
            brc_ff <= BSL_BRC_RST;
            dis_ff <= BSL_DIS_RST;
            mto_lim_ff <= BSL_MTO_RST;
        end else if (wr_fire) begin
            if (avs_address == BSL_OFF_CMD) cmd_ff <= avs_writedata[1:0];
            if (avs_address == BSL_OFF_BRC) brc_ff <= avs_writedata[3:0];
            if (avs_address == BSL_OFF_DIS) dis_ff <= avs_writedata[5:0];
            if (avs_address == BSL_OFF_MTO)
                mto_lim_ff <= avs_writedata[15:0];
        end
    end

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] serr_sy_ff, lock_sy_ff;
    logic serr_n_ff, slock_n_ff, serr_fall;
    // a level only counts once the last two stages agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            serr_sy_ff <= 3'h7;
            lock_sy_ff <= 3'h7;
            serr_n_ff <= 1'b1;
            slock_n_ff <= 1'b1;
        end else begin
            serr_sy_ff <= {serr_sy_ff[1:0], s_serr_n};
            lock_sy_ff <= {lock_sy_ff[1:0], s_lock_in_n};
            if (serr_sy_ff[1] == serr_sy_ff[2]) serr_n_ff <= serr_sy_ff[2];
            if (lock_sy_ff[1] == lock_sy_ff[2]) slock_n_ff <= lock_sy_ff[2];
        end
    end
    assign serr_fall = serr_n_ff & (serr_sy_ff[1] == serr_sy_ff[2])
        & ~serr_sy_ff[2];

    // ****************************************************************
    // retry counters, one per queue slot
    // ****************************************************************
    logic [RW-1:0] rty_cnt_ff [NQ];
    logic rty_hit;
    bsl_qkind_t disc_kind_ff;
    assign rty_hit = q_retry && rty_cnt_ff[q_retry_slot] == RTY_LAST;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < NQ; i++) rty_cnt_ff[i] <= '0;
            q_discard <= 1'b0;
            q_discard_slot <= '0;
            disc_kind_ff <= BSL_Q_PW;
        end else begin
            q_discard <= rty_hit;
            if (q_retry) begin
                q_discard_slot <= q_retry_slot;
                disc_kind_ff <= q_retry_kind;
                rty_cnt_ff[q_retry_slot] <= rty_hit ? '0
                    : rty_cnt_ff[q_retry_slot] + 1'b1;
            end
            if (q_done && !(q_retry && q_retry_slot == q_done_slot))
                rty_cnt_ff[q_done_slot] <= '0;
        end
    end

    // ****************************************************************
    // system error generation
    // ****************************************************************
    logic mto_exp;
    logic [7:0] ev, masked, w1c_st;
    logic fire;
    always_comb begin
        ev = 8'h00;
        ev[BSL_EV_PW_PAR] = pw_perr_rep & ~pw_perr_as_tgt
            & cmd_ff[BSL_CMD_PERR] & brc_ff[BSL_BRC_PERR];
        ev[BSL_EV_PW_TABT] = pw_tabort;
        ev[BSL_EV_PW_MABT] = pw_mabort & brc_ff[BSL_BRC_MAM];
        ev[BSL_EV_PW_RTY] = q_discard && disc_kind_ff == BSL_Q_PW;
        ev[BSL_EV_DW_RTY] = q_discard && disc_kind_ff == BSL_Q_DW;
        ev[BSL_EV_DR_RTY] = q_discard && disc_kind_ff == BSL_Q_DR;
        ev[BSL_EV_MTO] = mto_exp & brc_ff[BSL_BRC_MTO];
        ev[BSL_EV_SFWD] = serr_fall & brc_ff[BSL_BRC_FWD];
    end
    // timeout and forward have no disable bit of their own
    assign masked = ev & ~{2'b00, dis_ff};
    assign fire = cmd_ff[BSL_CMD_SERR] & (|masked);
    assign w1c_st = f_w1c({5'h00, st_ff},
        {5'h00, dpe_event & dpe_down & dpe_sec_bus & dpe_master
            & brc_ff[BSL_BRC_PERR], ev[BSL_EV_SFWD], fire},
        (wr_fire && avs_address == BSL_OFF_STAT) ? avs_writedata[7:0]
            : 8'h00);

    // serr is a one-cycle low pulse; reason bits are sticky until cleared
    always_ff @(posedge clk) begin
        if (!nrst) begin
            p_serr_n <= 1'b1;
            st_ff <= 3'h0;
            rsn_ff <= 8'h00;
        end else begin
            p_serr_n <= ~fire;
            st_ff <= w1c_st[2:0];
            rsn_ff <= f_w1c(rsn_ff, fire ? masked : 8'h00,
                (wr_fire && avs_address == BSL_OFF_RSN)
                    ? avs_writedata[7:0] : 8'h00);
        end
    end

    // ****************************************************************
    // downstream lock control
    // ****************************************************************
    logic pend_ff, locked, match;
    logic [15:0] mto_cnt_ff;
    bsl_resp_t nxt_resp;
    assign locked = pend_ff & ~link.lock_n;
    assign match = fwd_addr == sec_addr && fwd_cmd == sec_cmd
        && fwd_be == sec_be;
    assign mto_exp = lk_ff == LK_WAITI && mto_cnt_ff == mto_lim_ff;

    // requests are judged the cycle after their address phase
    always_comb begin
        nxt_lk = lk_ff;
        nxt_resp = BSL_RESP_NONE;
        case (lk_ff)
            LK_IDLE: if (pend_ff) begin
                if (locked && fwd_cmd != 4'h0 && link.req_read) begin
                    nxt_resp = BSL_RESP_RETRY;
                    nxt_lk = LK_QUEUED;
                end else begin
                    nxt_resp = BSL_RESP_FWD;
                end
            end
            LK_QUEUED: if (!prior_busy) nxt_lk = LK_SECW;
            LK_SECW: if (slock_n_ff && sec_idle) nxt_lk = LK_SECA;
            LK_SECA: nxt_lk = LK_SECR;
            LK_SECR: if (sec_done) begin
                nxt_lk = (sec_status == BSL_SEC_OK) ? LK_WAITI : LK_ABORT;
            end
            LK_WAITI: begin
                if (locked && match) begin
                    nxt_resp = BSL_RESP_DATA;
                    nxt_lk = LK_HELD;
                end else if (mto_exp) begin
                    nxt_lk = LK_IDLE;
                end
            end
            LK_HELD: begin
                if (locked) nxt_resp = BSL_RESP_FWD;
                else if (link.lock_n && link.frame_n && !pend_ff)
                    nxt_lk = LK_IDLE;
            end
            LK_ABORT: if (locked && match) begin
                nxt_resp = BSL_RESP_ABORT;
                nxt_lk = LK_IDLE;
            end
            default: nxt_lk = LK_IDLE;
        endcase
        // everything else crossing while the lock is pending is retried
        if (pend_ff && nxt_resp == BSL_RESP_NONE)
            nxt_resp = BSL_RESP_RETRY;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            lk_ff <= LK_IDLE;
            pend_ff <= 1'b0;
            link.resp <= BSL_RESP_NONE;
            fwd_valid <= 1'b0;
            fwd_locked <= 1'b0;
            sec_start <= 1'b0;
            up_fwd <= 1'b0;
        end else begin
            lk_ff <= nxt_lk;
            pend_ff <= link.req_valid;
            link.resp <= nxt_resp;
            fwd_valid <= nxt_resp == BSL_RESP_FWD;
            fwd_locked <= nxt_resp == BSL_RESP_FWD && lk_ff == LK_HELD;
            sec_start <= lk_ff == LK_SECW && nxt_lk == LK_SECA;
            up_fwd <= up_req;
        end
    end

    // request fields captured at the address phase, lock copy kept apart
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fwd_addr <= 32'h0000_0000;
            fwd_cmd <= 4'h0;
            fwd_be <= 4'h0;
            sec_addr <= 32'h0000_0000;
            sec_cmd <= 4'h0;
            sec_be <= 4'h0;
            sec_par <= 1'b0;
            link.rdata <= 32'h0000_0000;
        end else begin
            if (link.req_valid) begin
                fwd_addr <= link.req_addr;
                fwd_cmd <= link.req_cmd;
                fwd_be <= link.req_be;
            end
            if (lk_ff == LK_IDLE && nxt_lk == LK_QUEUED) begin
                sec_addr <= fwd_addr;
                sec_cmd <= fwd_cmd;
                sec_be <= fwd_be;
                sec_par <= link.req_par;
            end
            if (lk_ff == LK_SECR && sec_done) link.rdata <= sec_rdata;
        end
    end

    // master timeout waiting for the initiator to come back
    always_ff @(posedge clk) begin
        if (!nrst) mto_cnt_ff <= 16'h0000;
        else if (lk_ff == LK_WAITI) mto_cnt_ff <= mto_cnt_ff + 1'b1;
        else mto_cnt_ff <= 16'h0000;
    end

    // lock drive: released in the address phase, pulled low afterwards
    assign s_lock_o_n = 1'b0;
    assign s_lock_oe = lk_ff == LK_SECR || lk_ff == LK_WAITI
        || lk_ff == LK_HELD;
    // a foreign secondary lock never touches primary state
    assign pri_lock_held = lk_ff == LK_HELD;
    assign sec_lock_held = lk_ff == LK_WAITI || lk_ff == LK_HELD;
    // locked reads are never prefetched downstream
    assign fwd_no_prefetch = lk_ff != LK_IDLE;
endmodule : bsl_bridge_ctl

// File: core/bsl_initiator.sv
// primary initiator end: issues requests and runs the lock sequence
// assumes the bridge answers on link.resp and other primary masters
// report bus idle and lock state on ext_idle / ext_lock_n
`timescale 1ns/1ps
module bsl_initiator import bsl_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    bsl_link_if.ini link,
    input wire logic cmd_go,
    input wire logic cmd_locked,
    input wire logic cmd_read,
    input wire logic cmd_mem,
    input wire logic [31:0] cmd_addr,
    input wire logic [3:0] cmd_cmd,
    input wire logic [3:0] cmd_be,
    input wire logic cmd_par,
    input wire logic cmd_release,
    input wire logic ext_idle,
    input wire logic ext_lock_n,
    output logic busy,
    output logic done,
    output bsl_resp_t done_resp,
    output logic [31:0] done_rdata,
    output logic lock_owner
);
    typedef enum logic [1:0] {I_IDLE, I_WAIT, I_ADDR, I_DATA} bsl_ist_t;
    bsl_ist_t st_ff;
    logic lk_ff;

    // ****************************************************************
    // handshake outputs follow the state directly
    // ****************************************************************
    assign link.req_valid = st_ff == I_ADDR;
    assign link.frame_n = !(st_ff == I_ADDR || st_ff == I_DATA);
    assign busy = st_ff != I_IDLE;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    // lock is set only after the address phase; once a locked read gets data it stays held until cmd_release or an abort answer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_ff <= I_IDLE;
            lk_ff <= 1'b0;
            link.lock_n <= 1'b1;
            lock_owner <= 1'b0;
            done <= 1'b0;
            done_resp <= BSL_RESP_NONE;
            done_rdata <= 32'h0000_0000;
            link.req_read <= 1'b0;
            link.req_mem <= 1'b0;
            link.req_addr <= 32'h0000_0000;
            link.req_cmd <= 4'h0;
            link.req_be <= 4'h0;
            link.req_par <= 1'b0;
        end else begin
            done <= 1'b0;
            case (st_ff)
                I_IDLE: begin
                    if (cmd_release) begin
                        lock_owner <= 1'b0;
                        link.lock_n <= 1'b1;
                    end else if (cmd_go) begin
                        lk_ff <= cmd_locked;
                        link.req_read <= cmd_read;
                        link.req_mem <= cmd_mem;
                        link.req_addr <= cmd_addr;
                        link.req_cmd <= cmd_cmd;
                        link.req_be <= cmd_be;
                        link.req_par <= cmd_par;
                        if (cmd_locked && !lock_owner && !cmd_read) begin
                            done <= 1'b1;
                            done_resp <= BSL_RESP_NONE;
                        end else if (cmd_locked && !lock_owner) begin
                            st_ff <= I_WAIT;
                        end else begin
                            st_ff <= I_ADDR;
                        end
                    end
                end
                I_WAIT: if (ext_idle && ext_lock_n) begin
                    st_ff <= I_ADDR;
                end
                I_ADDR: begin
                    st_ff <= I_DATA;
                    if (lk_ff) link.lock_n <= 1'b0;
                end
                I_DATA: if (link.resp != BSL_RESP_NONE) begin
                    st_ff <= I_IDLE;
                    done <= 1'b1;
                    done_resp <= link.resp;
                    done_rdata <= link.rdata;
                    if (lk_ff && link.resp == BSL_RESP_DATA)
                        lock_owner <= 1'b1;
                    // a retried first lock or an abort gives the lock up
                    if ((link.resp == BSL_RESP_RETRY && !lock_owner)
                        || link.resp == BSL_RESP_ABORT) begin
                        link.lock_n <= 1'b1;
                        lock_owner <= 1'b0;
                    end
                end
                default: st_ff <= I_IDLE;
            endcase
        end
    end
endmodule : bsl_initiator

// File: verification/bsl_link_sva.sv
// link checker: addressing, lock sequence and answer timing
// assumes instantiation beside the link interface, on one clock
`timescale 1ns/1ps
module bsl_link_sva import bsl_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    input wire logic frame_n,
    input wire logic lock_n,
    input wire bsl_resp_t resp
);
    // ****
    // link properties
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_addr_lock_free: assert property (req_valid |-> lock_n)
        else $error("lock low in address phase");
    chk_addr_frame: assert property (req_valid |-> !frame_n)
        else $error("frame high in address phase");
    chk_lock_late: assert property (
        $fell(lock_n) |-> $past(req_valid))
        else $error("lock not one cycle after address");
    chk_answer_time: assert property (
        req_valid |-> ##2 resp != BSL_RESP_NONE)
        else $error("answer missing two cycles on");
    chk_answer_cause: assert property (
        resp != BSL_RESP_NONE |-> $past(req_valid, 2))
        else $error("answer without request");
    chk_answer_pulse: assert property (
        resp != BSL_RESP_NONE |=> resp == BSL_RESP_NONE)
        else $error("answer longer than a cycle");
    chk_one_request: assert property (
        req_valid |=> !req_valid [*2])
        else $error("request before answer");
    chk_fields_hold: assert property (
        req_valid |=> $stable(req_addr) [*2])
        else $error("address moved in flight");
    cov_retry: cover property (resp == BSL_RESP_RETRY);
    cov_abort: cover property (resp == BSL_RESP_ABORT);
    cov_data: cover property (resp == BSL_RESP_DATA);
    cov_fwd: cover property (resp == BSL_RESP_FWD);
endmodule : bsl_link_sva

// File: verification/test_bridge_serr_and_lock_control.sv
// bench: initiator and bridge joined over the link, avalon register use
// assumes package, interface and both ends compiled beforehand
`timescale 1ns/1ps
module test_bridge_serr_and_lock_control import bsl_pkg::*; ;
    // ****
    // stimulus and checks
    // ****
    logic clk, nrst = 0, avs_read = 0, avs_write = 0, sec_done = 0;
    logic cmd_go = 0, cmd_locked = 0, cmd_release = 0, s_serr_n = 1;
    logic s_lock_in_n = 1, sec_idle = 1, prior_busy = 0, ext_idle = 1;
    logic ext_lock_n = 1, cmd_read = 1, cmd_mem = 1, cmd_par = 0;
    logic [4:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, sec_rdata = 0, q, cmd_addr = 'h1000;
    logic [3:0] cmd_cmd = 'h6, cmd_be = 0;
    logic [1:0] q_retry_slot = 0, q_done_slot = 0;
    logic [7:0] evv = 0;
    bsl_sec_t sec_status = BSL_SEC_OK;
    bsl_qkind_t q_retry_kind = BSL_Q_PW;
    // one-cycle event inputs share one vector so a task can pulse any set
    wire pw_tabort = evv[0], pw_perr_rep = evv[1], q_retry = evv[2];
    wire up_req = evv[3], dpe_event = evv[4], dpe_down = evv[4];
    wire dpe_sec_bus = evv[4], dpe_master = evv[4], pw_perr_as_tgt = evv[5];
    wire pw_mabort = evv[6], q_done = evv[7];
    logic [31:0] avs_readdata, sec_addr, fwd_addr, done_rdata;
    logic avs_waitrequest, s_lock_o_n, s_lock_oe, sec_start, sec_par;
    logic [3:0] sec_cmd, sec_be, fwd_cmd, fwd_be;
    logic q_discard, fwd_valid, fwd_locked, fwd_no_prefetch, up_fwd;
    logic [1:0] q_discard_slot;
    logic p_serr_n, pri_lock_held, sec_lock_held, busy, done, lock_owner;
    bsl_resp_t done_resp;
    int fail_count = 0, checks_done = 0;
    bsl_link_if lk();
    bsl_bridge_ctl #(.RETRY_LIMIT(4)) i_bsl_bridge_ctl (.link(lk), .*);
    bsl_initiator i_bsl_initiator (.link(lk), .*);
    bsl_link_sva i_bsl_link_sva (.clk, .nrst, .req_valid(lk.req_valid),
        .req_addr(lk.req_addr), .frame_n(lk.frame_n), .lock_n(lk.lock_n),
        .resp(lk.resp));
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : ck
    // avalon cycle: hold until waitrequest is low at a rising edge
    task automatic av(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : av
    task automatic rr(input logic [4:0] a, input logic [31:0] e);
        av(1'b0, a, 0);
        ck(q, e);
    endtask : rr
    // pulse events for one cycle, then look at serr one cycle later
    task automatic ev(input logic [7:0] v, input logic e);
        @(posedge clk);
        evv <= v;
        @(posedge clk);
        evv <= 0;
        #1 ck(32'(p_serr_n), 32'(!e));
    endtask : ev
    task automatic go(input logic l, input bsl_resp_t e);
        @(posedge clk);
        cmd_go <= 1'b1;
        cmd_locked <= l;
        @(posedge clk);
        cmd_go <= 1'b0;
        while (done !== 1'b1) @(negedge clk);
        ck(32'(done_resp), 32'(e));
    endtask : go
    // queue a locked read and let the secondary side end it with s
    task automatic lock_q(input bsl_sec_t s);
        go(1'b1, BSL_RESP_RETRY);
        while (s_lock_oe !== 1'b1) @(negedge clk);
        @(posedge clk);
        sec_status <= s;
        sec_done <= 1'b1;
        @(posedge clk);
        sec_done <= 1'b0;
    endtask : lock_q
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    // watchdog well beyond the under two hundred cycles the sequence needs
    initial begin
        #400000;
        fail_count++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rr(BSL_OFF_CMD, 0);
        rr(BSL_OFF_MTO, 'h8000);
        rr(5'h18, 0);
        ev(1, 0);
        av(1'b1, BSL_OFF_CMD, 3);
        av(1'b1, BSL_OFF_BRC, 1);
        ev(1, 1);
        rr(BSL_OFF_STAT, 1);
        rr(BSL_OFF_RSN, 2);
        av(1'b1, BSL_OFF_DIS, 2);
        ev(1, 0);
        ev('h22, 0);
        ev('h02, 1);
        ev('h10, 0);
        rr(BSL_OFF_STAT, 5);
        repeat (4) ev(4, 0);
        ck(32'(q_discard), 1);
        @(posedge clk);
        #1 ck(32'(p_serr_n), 0);
        ev(8, 0);
        ck(32'(up_fwd), 1);
        lock_q(BSL_SEC_OK);
        ck(32'(s_lock_oe), 1);
        ck(sec_addr, 'h1000);
        go(1'b0, BSL_RESP_RETRY);
        go(1'b1, BSL_RESP_DATA);
        ck(32'(pri_lock_held & lock_owner), 1);
        ck(32'(fwd_no_prefetch), 1);
        rr(BSL_OFF_STAT, 'h3D);
        @(posedge clk);
        cmd_release <= 1'b1;
        @(posedge clk);
        cmd_release <= 1'b0;
        repeat (4) @(posedge clk);
        go(1'b0, BSL_RESP_FWD);
        // a secondary abort ends the sequence with no lock anywhere
        lock_q(BSL_SEC_TABT);
        go(1'b1, BSL_RESP_ABORT);
        ck(32'(sec_lock_held | s_lock_oe | lock_owner), 0);
        av(1'b1, BSL_OFF_MTO, 20);
        av(1'b1, BSL_OFF_BRC, 'hB);
        // forwarded secondary error, then an initiator that never returns
        s_serr_n <= 1'b0;
        while (p_serr_n !== 1'b0) @(posedge clk);
        s_serr_n <= 1'b1;
        rr(BSL_OFF_STAT, 7);
        lock_q(BSL_SEC_OK);
        while (p_serr_n !== 1'b0) @(negedge clk);
        ck(32'(s_lock_oe), 0);
        rr(BSL_OFF_RSN, 'hCB);
        final_report();
    end
endmodule : test_bridge_serr_and_lock_control
